// ### bench/rak_kp_model.sv
`timescale 1ns/100ps
`default_nettype none

module rak_kp_model (
  // clock
  input wire logic CLK,
  // keypad: keys wanted by the bench, finger lag in cycles
  input wire rak_pkg::rak_keys_type PRESS,
  input wire logic [3:0] LAG,
  output rak_pkg::rak_keys_type KEYS,
  // analog driver: level in uV (voltage) or nA (current)
  input wire logic [15:0] AOUT_CODE,
  input wire logic AOUT_CURRENT,
  output logic [31:0] LEVEL
);
  import rak_pkg::*;
  logic [3:0] wait_cnt = 4'h0;
  logic [63:0] scaled_uv;
  logic [63:0] scaled_na;

  // a released key reads open, so not pressed; a slow finger lags
  always_ff @(posedge CLK)
  begin
    if (PRESS == KEYS || wait_cnt >= LAG)
      wait_cnt <= 4'h0;
    else
      wait_cnt <= wait_cnt + 4'h1;
    if (wait_cnt >= LAG)
      KEYS <= PRESS;
  end

  // ideal converter, floor rounding
  always_comb
  begin
    scaled_uv = 64'(AOUT_CODE) * 64'd10000000 / 64'd65535;
    scaled_na = 64'd4000000 + 64'(AOUT_CODE) * 64'd16000000 / 64'd65535;
    LEVEL = AOUT_CURRENT ? scaled_na[31:0] : scaled_uv[31:0];
  end
endmodule : rak_kp_model

`default_nettype wire

// ### bench/tb_relay_analog_out_keypad_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

module tb_relay_analog_out_keypad_ctrl;
  import rak_pkg::*;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic wreq;
  logic [19:0] temp = 20'h0;
  logic [23:0] sens = 24'h0;
  logic [1:0] ity = 2'h0;
  logic cvalid = 1'b0;
  logic over = 1'b0;
  logic under = 1'b0;
  rak_keys_type press = '0;
  rak_keys_type keys;
  rak_keys_type kpulse;
  logic [3:0] lag = 4'h0;
  logic r1, r2, acur, ahi, alo;
  logic [15:0] code;
  logic [23:0] cdate;
  logic [3:0] bright;
  rak_msg_type msg;
  logic [31:0] level;
  logic [31:0] q;
  logic [31:0] rnd = 32'h7694;
  int n_fail = 0;
  int n_tests = 0;
  int pulses = 0;
  int p0;
  longint x, e, tk, f;
  longint fs_tab[6] = '{20000, 100000, 200000, 325000, 475000, 1000000};
  longint tv[3] = '{50000, 200000, 400000};
  int rc1[5] = '{0, 1, 2, 0, 3};
  int rc2[5] = '{0, 1, 2, 1, 3};

  initial
  begin
    forever #5 CLK = ~CLK;
  end

  rak_relay_aout_keypad #(.HOLD_CYCLES(20)) u_dut (
    .CLK(CLK), .RESET(RESET), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .TEMP_MK(temp),
    .SENSOR_VALUE(sens), .INPUT_TYPE(ity), .CURVE_VALID(cvalid),
    .OVER_CURVE(over), .UNDER_CURVE(under), .KEYS(keys), .RELAY_1(r1),
    .RELAY_2(r2), .AOUT_CODE(code), .AOUT_CURRENT(acur),
    .ALARM_HIGH(ahi), .ALARM_LOW(alo), .DISPLAY_MSG(msg),
    .CODE_DATE(cdate), .BRIGHTNESS(bright), .KEY_PULSE(kpulse));

  rak_kp_model u_far (.CLK(CLK), .PRESS(press), .LAG(lag), .KEYS(keys),
    .AOUT_CODE(code), .AOUT_CURRENT(acur), .LEVEL(level));

  always @(posedge CLK)
    if (kpulse != '0)
      pulses++;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // floor of a linear map onto 16 bits, pinned at full scale
  function automatic longint exp_code(input longint v, input longint fs);
    if (v >= fs)
      return 65535;
    return (v * ((64'hffff << 32) / fs)) >> 32;
  endfunction : exp_code

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic endt(input string s);
    $display("test %s done, mismatches so far %0d", s, n_fail);
  endtask : endt

  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
  endtask : tick

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (wreq !== 1'b0 && n < 40);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 40)
      chk(32'h1, 32'h0);
  endtask : bus

  // message must stand while held and clear once all keys are up
  task automatic hold(input logic [3:0] k, input int cyc,
                      input rak_msg_type m);
    @(posedge CLK);
    press <= k;
    tick(cyc);
    chk(32'(msg), 32'(m));
    press <= '0;
    tick(12);
    chk(32'(msg), 32'(RAK_MSG_NORMAL));
  endtask : hold

  initial
  begin
    tick(4);
    RESET <= 1'b0;
    bus(1'b0, RAK_REG_CONFIG, 32'h0);
    chk(q, 32'h80a0);
    chk(bright, 4'h8);
    endt("defaults");
    cvalid <= 1'b1;
    bus(1'b1, RAK_REG_LOW_SP, 32'd100000);
    bus(1'b1, RAK_REG_HIGH_SP, 32'd300000);
    for (int m = 0; m < 5; m++)
    begin
      bus(1'b1, RAK_REG_CONFIG, 32'h81a0 | rc1[m] | (rc2[m] << 2));
      for (int t = 0; t < 3; t++)
      begin
        temp <= tv[t][19:0];
        tick(4);
        e = rc1[m] == 1 || (rc1[m] == 2 && t == 0);
        chk(r1, e[0]);
        e = rc2[m] == 1 || (rc2[m] == 2 && t == 2);
        chk(r2, e[0]);
      end
    end
    temp <= 20'd200000;
    over <= 1'b1;
    tick(4);
    chk(ahi, 1'b1);
    over <= 1'b0;
    endt("relays");
    for (int r = 0; r < 6; r++)
      for (int c = 0; c < 2; c++)
      begin
        bus(1'b1, RAK_REG_CONFIG, 32'h8000 | (r << 5) | (c << 4));
        for (int k = 0; k < 4; k++)
        begin
          rnd = lfsr(rnd);
          x = (k == 0) ? 0 : (k == 1) ? fs_tab[r] :
              longint'(rnd[19:0]) % fs_tab[r];
          if (k == 3)
            x = fs_tab[r] + x % 1000 + 1;
          temp <= x[19:0];
          sens <= rnd[23:0];
          tick(4);
          e = exp_code(x, fs_tab[r]);
          chk(code, e[15:0]);
          chk(acur, c[0]);
          f = c ? 4000000 + e * 16000000 / 65535 : e * 10000000 / 65535;
          chk(level, f[31:0]);
          if (r == 3 && c == 1 && k < 3)
          begin
            tk = -81250 + longint'(level) * 203125 / 10000000 - x;
            chk(tk < 16 && tk > -16, 1'b1);
          end
        end
      end
    cvalid <= 1'b0;
    bus(1'b1, RAK_REG_CONFIG, 32'h80a0);
    for (int ty = 0; ty < 4; ty++)
    begin
      rnd = lfsr(rnd);
      f = (ty == 1) ? 1000000 : 10000000;
      x = longint'(rnd[23:0]) % (f + f / 8);
      ity <= ty[1:0];
      sens <= x[23:0];
      tick(4);
      e = exp_code(x, f);
      chk(code, e[15:0]);
    end
    endt("analog");
    bus(1'b1, RAK_REG_CURVE_PTR, 32'h0515);
    bus(1'b1, RAK_REG_CURVE_UNITS, 32'h123456);
    bus(1'b1, RAK_REG_CURVE_PTR, 32'h0005);
    bus(1'b1, RAK_REG_CURVE_UNITS, 32'habcdef);
    bus(1'b0, RAK_REG_CURVE_UNITS, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, RAK_REG_CURVE_PTR, 32'hc815);
    bus(1'b1, RAK_REG_CURVE_UNITS, 32'h777);
    bus(1'b0, RAK_REG_CURVE_UNITS, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, RAK_REG_CURVE_COUNT, (i == 0) ? 1 : (i == 1) ? 201 : 2);
      bus(1'b0, RAK_REG_CURVE_COUNT, 32'h0);
      chk(q, (i == 1) ? 200 : 2);
    end
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, RAK_REG_CONFIG, 32'h80e0);
    bus(1'b0, RAK_REG_CONFIG, 32'h0);
    chk(q, 32'h80a0);
    endt("curves");
    bus(1'b1, RAK_REG_CONFIG, 32'h3015);
    hold(4'h8, 12, RAK_MSG_NORMAL);
    hold(4'h8, 40, RAK_MSG_LOCKED);
    lag <= 4'h3;
    p0 = pulses;
    hold(4'h2, 12, RAK_MSG_NORMAL);
    hold(4'h3, 40, RAK_MSG_NORMAL);
    hold(4'h4, 12, RAK_MSG_NORMAL);
    chk(pulses, p0);
    bus(1'b0, RAK_REG_CONFIG, 32'h0);
    chk(q, 32'h3015);
    bus(1'b1, RAK_REG_CONFIG, 32'h3315);
    cvalid <= 1'b1;
    temp <= 20'd200000;
    under <= 1'b1;
    tick(4);
    under <= 1'b0;
    tick(4);
    chk(alo, 1'b1);
    hold(4'h4, 12, RAK_MSG_NORMAL);
    chk(alo, 1'b0);
    hold(4'h8, 40, RAK_MSG_UNLOCKED);
    hold(4'h2, 12, RAK_MSG_NORMAL);
    chk(pulses != p0, 1'b1);
    hold(4'h4, 12, RAK_MSG_DATE);
    chk(cdate, RAK_CODE_DATE);
    endt("lock");
    hold(4'h3, 40, RAK_MSG_ALL_ON);
    bus(1'b0, RAK_REG_CONFIG, 32'h0);
    chk(q, 32'h80a0);
    chk(bright, 4'h8);
    bus(1'b0, RAK_REG_HIGH_SP, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, RAK_REG_CURVE_PTR, 32'h0515);
    bus(1'b0, RAK_REG_CURVE_UNITS, 32'h0);
    chk(q, 32'h123456);
    endt("restore");
    close_out();
  end

  // whole run is under a thousand cycles
  initial
  begin
    tick(20000);
    n_fail++;
    close_out();
  end
endmodule : tb_relay_analog_out_keypad_ctrl

`default_nettype wire

// ### logic/rak_pkg.sv
`default_nettype none

package rak_pkg;

  // timing
  localparam int RAK_CLK_HZ = 100_000_000;
  localparam int RAK_HOLD_TIME_S = 10;
  localparam int RAK_HOLD_CYCLES = RAK_HOLD_TIME_S * RAK_CLK_HZ;

  // register byte offsets
  localparam logic [7:0] RAK_REG_CONFIG = 8'h00;
  localparam logic [7:0] RAK_REG_HIGH_SP = 8'h04;
  localparam logic [7:0] RAK_REG_LOW_SP = 8'h08;
  localparam logic [7:0] RAK_REG_STATUS = 8'h0c;
  localparam logic [7:0] RAK_REG_CURVE_PTR = 8'h10;
  localparam logic [7:0] RAK_REG_CURVE_UNITS = 8'h14;
  localparam logic [7:0] RAK_REG_CURVE_KELVIN = 8'h18;
  localparam logic [7:0] RAK_REG_CURVE_COUNT = 8'h1c;

  // relay functions
  localparam logic [1:0] RAK_RELAY_OFF = 2'h0;
  localparam logic [1:0] RAK_RELAY_ON = 2'h1;
  localparam logic [1:0] RAK_RELAY_FOLLOW = 2'h2;

  // input types
  localparam logic [1:0] RAK_IN_DIODE = 2'h0;
  localparam logic [1:0] RAK_IN_PT100 = 2'h1;
  localparam logic [1:0] RAK_IN_PT1000 = 2'h2;
  localparam logic [1:0] RAK_IN_NTC = 2'h3;

  // full scales: kelvin ranges in mK, sensor scales in uV or mOhm
  localparam logic [63:0] RAK_FS_R0 = 64'd20_000;
  localparam logic [63:0] RAK_FS_R1 = 64'd100_000;
  localparam logic [63:0] RAK_FS_R2 = 64'd200_000;
  localparam logic [63:0] RAK_FS_R3 = 64'd325_000;
  localparam logic [63:0] RAK_FS_R4 = 64'd475_000;
  localparam logic [63:0] RAK_FS_R5 = 64'd1_000_000;
  localparam logic [63:0] RAK_FS_DIODE = 64'd10_000_000;
  localparam logic [63:0] RAK_FS_1K = 64'd1_000_000;
  localparam logic [63:0] RAK_FS_10K = 64'd10_000_000;
  localparam logic [63:0] RAK_SCALE_NUM = 64'hffff_0000_0000;
  localparam int RAK_SCALE_SHIFT = 32;
  localparam logic [15:0] RAK_CODE_FULL = 16'hffff;
  localparam logic [15:0] RAK_CODE_ZERO = 16'h0000;

  // curve storage
  localparam logic [7:0] RAK_CURVE_PAIRS = 8'hc8;
  localparam logic [7:0] RAK_CURVE_MIN = 8'h02;
  localparam logic [4:0] RAK_USER_LOC = 5'h15;

  // firmware code date, MMDDYY in BCD; value arbitrary
  localparam logic [23:0] RAK_CODE_DATE = 24'h010100;

  typedef struct packed {
    logic [3:0] bright;
    logic [1:0] spare;
    logic latch;
    logic alarm_en;
    logic [2:0] range;
    logic current;
    logic [1:0] relay2;
    logic [1:0] relay1;
  } rak_cfg_type;

  localparam logic [15:0] RAK_CFG_DEFAULT = 16'h80a0;
  localparam logic [2:0] RAK_RANGE_MAX = 3'h5;

  typedef struct packed {
    logic [15:0] code;
    logic [10:0] spare;
    logic locked;
    logic alarm_high;
    logic alarm_low;
    logic relay2;
    logic relay1;
  } rak_status_type;

  typedef struct packed {
    logic [15:0] spare;
    logic [7:0] idx;
    logic [2:0] pad;
    logic [4:0] loc;
  } rak_ptr_type;

  typedef struct packed {
    logic enter;
    logic select;
    logic up;
    logic down;
  } rak_keys_type;

  typedef enum logic [2:0] {
    RAK_MSG_NORMAL,
    RAK_MSG_LOCKED,
    RAK_MSG_UNLOCKED,
    RAK_MSG_ALL_ON,
    RAK_MSG_DATE
  } rak_msg_type;

  typedef enum {
    KP_IDLE,
    KP_ENTER,
    KP_UPDN,
    KP_SHOW_LOCK,
    KP_SHOW_UNLOCK,
    KP_SHOW_DFLT,
    KP_DATE
  } rak_kp_state_type;

endpackage : rak_pkg

`default_nettype wire

// ### logic/rak_relay_aout_keypad.sv
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module rak_relay_aout_keypad #(
  parameter int HOLD_CYCLES = rak_pkg::RAK_HOLD_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // avalon-mm slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // measurement, same clock
  input wire logic [19:0] TEMP_MK,
  input wire logic [23:0] SENSOR_VALUE,
  input wire logic [1:0] INPUT_TYPE,
  input wire logic CURVE_VALID,
  input wire logic OVER_CURVE,
  input wire logic UNDER_CURVE,
  // front-panel keys, asynchronous
  input wire rak_pkg::rak_keys_type KEYS,
  // relays and analog output
  output logic RELAY_1,
  output logic RELAY_2,
  output logic [15:0] AOUT_CODE,
  output logic AOUT_CURRENT,
  // alarms and display
  output logic ALARM_HIGH,
  output logic ALARM_LOW,
  output rak_pkg::rak_msg_type DISPLAY_MSG,
  output logic [23:0] CODE_DATE,
  output logic [3:0] BRIGHTNESS,
  output rak_pkg::rak_keys_type KEY_PULSE
);
  import rak_pkg::*;

  rak_cfg_type cfg;
  logic [19:0] high_sp;
  logic [19:0] low_sp;
  rak_ptr_type ptr;
  logic [7:0] curve_count;
  logic [23:0] cu_units [0:199];
  logic [19:0] cu_kelvin [0:199];
  logic ack;
  logic wr;
  logic [31:0] rd_word;
  logic [31:0] old_word;
  logic [31:0] wmerged;
  rak_keys_type key_meta;
  rak_keys_type key_sync;
  rak_keys_type key_prev;
  rak_keys_type key_rise;
  rak_kp_state_type kp_state;
  logic [31:0] hold_cnt;
  logic hold_done;
  logic locked;
  logic restore;
  logic raw_high;
  logic raw_low;
  logic [63:0] fs;
  logic [63:0] rc;
  logic [23:0] x;
  logic [63:0] prod;
  logic ptr_user_ok;

  // bus slave: one wait cycle, then answer
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
  assign wr = AVS_WRITE & ack;

  always_ff @(posedge CLK)
  begin
    if (RESET)
      ack <= 1'b0;
    else
      ack <= (AVS_READ | AVS_WRITE) & ~ack;
  end

  always_comb
  begin
    case (AVS_ADDRESS)
      RAK_REG_CONFIG: old_word = {16'h0000, cfg};
      RAK_REG_HIGH_SP: old_word = {12'h000, high_sp};
      RAK_REG_LOW_SP: old_word = {12'h000, low_sp};
      RAK_REG_CURVE_PTR: old_word = ptr;
      RAK_REG_CURVE_COUNT: old_word = {24'h000000, curve_count};
      default: old_word = 32'h0000_0000;
    endcase
    for (int i = 0; i < 4; i++)
    begin
      wmerged[i*8 +: 8] = AVS_BYTEENABLE[i] ? AVS_WRITEDATA[i*8 +: 8]
                                            : old_word[i*8 +: 8];
    end
  end

  always_comb
  begin
    case (AVS_ADDRESS)
      RAK_REG_STATUS:
        rd_word = rak_status_type'{code: AOUT_CODE, spare: 11'h000,
                                   locked: locked, alarm_high: ALARM_HIGH,
                                   alarm_low: ALARM_LOW, relay2: RELAY_2,
                                   relay1: RELAY_1};
      RAK_REG_CURVE_UNITS:
        rd_word = ptr_user_ok ? {8'h00, cu_units[ptr.idx]} : 32'h0000_0000;
      RAK_REG_CURVE_KELVIN:
        rd_word = ptr_user_ok ? {12'h000, cu_kelvin[ptr.idx]}
                              : 32'h0000_0000;
      default: rd_word = old_word;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      AVS_READDATA <= 32'h0000_0000;
    else if (AVS_READ & ~ack)
      AVS_READDATA <= rd_word;
  end

  // settings; a restore overrides a bus write in the same cycle
  always_ff @(posedge CLK)
  begin
    if (RESET | restore)
    begin
      cfg <= rak_cfg_type'(RAK_CFG_DEFAULT);
      high_sp <= 20'h00000;
      low_sp <= 20'h00000;
    end
    else if (wr)
    begin
      if (AVS_ADDRESS == RAK_REG_CONFIG)
      begin
        cfg <= rak_cfg_type'(wmerged[15:0]);
        if (wmerged[7:5] > RAK_RANGE_MAX)
          cfg.range <= RAK_RANGE_MAX;
      end
      if (AVS_ADDRESS == RAK_REG_HIGH_SP)
        high_sp <= wmerged[19:0];
      if (AVS_ADDRESS == RAK_REG_LOW_SP)
        low_sp <= wmerged[19:0];
    end
  end

  // user curve: no reset and no restore touches it
  assign ptr_user_ok = (ptr.loc == RAK_USER_LOC)
                       && (ptr.idx < RAK_CURVE_PAIRS);

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      ptr <= '0;
      curve_count <= RAK_CURVE_MIN;
    end
    else if (wr && AVS_ADDRESS == RAK_REG_CURVE_PTR)
      ptr <= rak_ptr_type'({16'h0000, wmerged[15:0]});
    else if (wr && AVS_ADDRESS == RAK_REG_CURVE_COUNT)
    begin
      if (wmerged[7:0] < RAK_CURVE_MIN)
        curve_count <= RAK_CURVE_MIN;
      else if (wmerged[7:0] > RAK_CURVE_PAIRS)
        curve_count <= RAK_CURVE_PAIRS;
      else
        curve_count <= wmerged[7:0];
    end
  end

  always_ff @(posedge CLK)
  begin
    // keypad never reaches these; bus only
    if (wr && ptr_user_ok && AVS_ADDRESS == RAK_REG_CURVE_UNITS)
      cu_units[ptr.idx] <= AVS_WRITEDATA[23:0];
    if (wr && ptr_user_ok && AVS_ADDRESS == RAK_REG_CURVE_KELVIN)
      cu_kelvin[ptr.idx] <= AVS_WRITEDATA[19:0];
  end

  // key synchroniser and edge detect
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      key_meta <= '0;
      key_sync <= '0;
      key_prev <= '0;
    end
    else
    begin
      key_meta <= KEYS;
      key_sync <= key_meta;
      key_prev <= key_sync;
    end
  end

  assign key_rise = key_sync & ~key_prev;

  always_ff @(posedge CLK)
  begin
    if (RESET | locked)
      KEY_PULSE <= '0;
    else
      KEY_PULSE <= key_rise;
  end

  // keypad hold machine
  assign hold_done = (hold_cnt == 32'(HOLD_CYCLES - 1));

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      kp_state <= KP_IDLE;
      hold_cnt <= 32'h0000_0000;
      locked <= 1'b0;
      restore <= 1'b0;
    end
    else
    begin
      restore <= 1'b0;
      case (kp_state)
        KP_IDLE:
        begin
          hold_cnt <= 32'h0000_0000;
          if (key_sync.enter && !key_sync.up && !key_sync.down)
            kp_state <= KP_ENTER;
          else if (key_sync.up && key_sync.down && !locked)
            kp_state <= KP_UPDN;
          else if (key_sync.select && !locked)
            kp_state <= KP_DATE;
        end
        KP_ENTER:
        begin
          hold_cnt <= hold_cnt + 32'h0000_0001;
          if (!key_sync.enter)
            kp_state <= KP_IDLE;
          else if (hold_done)
          begin
            locked <= ~locked;
            kp_state <= locked ? KP_SHOW_UNLOCK : KP_SHOW_LOCK;
          end
        end
        KP_UPDN:
        begin
          hold_cnt <= hold_cnt + 32'h0000_0001;
          if (!(key_sync.up && key_sync.down))
            kp_state <= KP_IDLE;
          else if (hold_done)
          begin
            restore <= 1'b1;
            locked <= 1'b0;
            kp_state <= KP_SHOW_DFLT;
          end
        end
        KP_SHOW_LOCK, KP_SHOW_UNLOCK, KP_SHOW_DFLT:
        begin
          // message stays until every key is let go
          if (key_sync == '0)
            kp_state <= KP_IDLE;
        end
        KP_DATE:
        begin
          if (!key_sync.select)
            kp_state <= KP_IDLE;
        end
        default: kp_state <= KP_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      DISPLAY_MSG <= RAK_MSG_NORMAL;
    else
      case (kp_state)
        KP_SHOW_LOCK: DISPLAY_MSG <= RAK_MSG_LOCKED;
        KP_SHOW_UNLOCK: DISPLAY_MSG <= RAK_MSG_UNLOCKED;
        KP_SHOW_DFLT: DISPLAY_MSG <= RAK_MSG_ALL_ON;
        KP_DATE: DISPLAY_MSG <= RAK_MSG_DATE;
        default: DISPLAY_MSG <= RAK_MSG_NORMAL;
      endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      CODE_DATE <= 24'h000000;
    else
      CODE_DATE <= RAK_CODE_DATE;
  end

  // alarms: no curve means no new trip; latched ones clear on select
  assign raw_high = cfg.alarm_en && CURVE_VALID
                    && (TEMP_MK > high_sp || OVER_CURVE);
  assign raw_low = cfg.alarm_en && CURVE_VALID
                   && (TEMP_MK < low_sp || UNDER_CURVE);

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      ALARM_HIGH <= 1'b0;
      ALARM_LOW <= 1'b0;
    end
    else
    begin
      // a new trip wins over a clear in the same cycle
      ALARM_HIGH <= raw_high
                    | (cfg.latch & ALARM_HIGH & ~key_rise.select);
      ALARM_LOW <= raw_low
                   | (cfg.latch & ALARM_LOW & ~key_rise.select);
    end
  end

  // relays
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      RELAY_1 <= 1'b0;
      RELAY_2 <= 1'b0;
    end
    else
    begin
      RELAY_1 <= (cfg.relay1 == RAK_RELAY_ON)
                 || (cfg.relay1 == RAK_RELAY_FOLLOW
                     && ALARM_LOW);
      RELAY_2 <= (cfg.relay2 == RAK_RELAY_ON)
                 || (cfg.relay2 == RAK_RELAY_FOLLOW
                     && ALARM_HIGH);
    end
  end

  // analog scaling by reciprocal multiply, avoids a divider
  always_comb
  begin
    if (CURVE_VALID)
    begin
      x = {4'h0, TEMP_MK};
      case (cfg.range)
        3'h0: fs = RAK_FS_R0;
        3'h1: fs = RAK_FS_R1;
        3'h2: fs = RAK_FS_R2;
        3'h3: fs = RAK_FS_R3;
        3'h4: fs = RAK_FS_R4;
        default: fs = RAK_FS_R5;
      endcase
    end
    else
    begin
      x = SENSOR_VALUE;
      case (INPUT_TYPE)
        RAK_IN_DIODE: fs = RAK_FS_DIODE;
        RAK_IN_PT100: fs = RAK_FS_1K;
        RAK_IN_PT1000: fs = RAK_FS_10K;
        default: fs = RAK_FS_10K;
      endcase
    end
    rc = RAK_SCALE_NUM / fs;
    prod = {40'h00_0000_0000, x} * rc;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      AOUT_CODE <= RAK_CODE_ZERO;
    else if ({40'h00_0000_0000, x} >= fs)
      AOUT_CODE <= RAK_CODE_FULL;
    else
      AOUT_CODE <= prod[RAK_SCALE_SHIFT +: 16];
  end

  // code 0..ffff maps to 0..10 V or 4..20 mA, so the host's
  // offset plus gain formula holds
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      AOUT_CURRENT <= 1'b0;
      BRIGHTNESS <= dflt_bright_of();
    end
    else
    begin
      AOUT_CURRENT <= cfg.current;
      BRIGHTNESS <= cfg.bright;
    end
  end

  function automatic logic [3:0] dflt_bright_of();
    rak_cfg_type d;
    d = rak_cfg_type'(RAK_CFG_DEFAULT);
    return d.bright;
  endfunction : dflt_bright_of

  // checks
  sequence s_enter_held;
    kp_state == KP_ENTER && key_sync.enter && hold_done;
  endsequence

  sequence s_updn_held;
    kp_state == KP_UPDN && key_sync.up && key_sync.down && hold_done;
  endsequence

  property p_lock_toggle;
    @(posedge CLK) disable iff (RESET)
    s_enter_held |=> locked != $past(locked) ##1
      (DISPLAY_MSG == RAK_MSG_LOCKED || DISPLAY_MSG == RAK_MSG_UNLOCKED);
  endproperty
  a_lock_toggle: assert property (p_lock_toggle)
    else $error("enter hold did not toggle lock");

  property p_restore;
    @(posedge CLK) disable iff (RESET)
    s_updn_held |=> restore ##1
      (cfg == rak_cfg_type'(RAK_CFG_DEFAULT) && !locked
       && DISPLAY_MSG == RAK_MSG_ALL_ON);
  endproperty
  a_restore: assert property (p_restore)
    else $error("up and down hold did not restore defaults");

  property p_locked_quiet;
    @(posedge CLK) disable iff (RESET)
    locked |=> KEY_PULSE == '0;
  endproperty
  a_locked_quiet: assert property (p_locked_quiet)
    else $error("key pulse seen while locked");

  property p_relay1;
    @(posedge CLK) disable iff (RESET)
    (cfg.relay1 == RAK_RELAY_FOLLOW) ##1
      (cfg.relay1 == RAK_RELAY_FOLLOW && $rose(ALARM_LOW))
      |=> RELAY_1;
  endproperty
  a_relay1: assert property (p_relay1)
    else $error("relay one did not follow low alarm");

  property p_relay2;
    @(posedge CLK) disable iff (RESET)
    cfg.relay2 == RAK_RELAY_FOLLOW ##1
      (cfg.relay2 == RAK_RELAY_FOLLOW) |-> RELAY_2 == $past(ALARM_HIGH);
  endproperty
  a_relay2: assert property (p_relay2)
    else $error("relay two does not match high alarm");

  property p_forced;
    @(posedge CLK) disable iff (RESET)
    (cfg.relay1 == RAK_RELAY_OFF && cfg.relay2 == RAK_RELAY_ON)
      |=> !RELAY_1 && RELAY_2;
  endproperty
  a_forced: assert property (p_forced)
    else $error("forced relay state wrong");

  property p_clamp;
    @(posedge CLK) disable iff (RESET)
    CURVE_VALID && cfg.range == 3'h0 && 64'(TEMP_MK) >= RAK_FS_R0
      |=> AOUT_CODE == RAK_CODE_FULL;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("code not clamped above range");

  property p_zero;
    @(posedge CLK) disable iff (RESET)
    CURVE_VALID && TEMP_MK == 20'h00000 |=> AOUT_CODE == RAK_CODE_ZERO;
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero kelvin did not give zero code");

  property p_std_refused;
    @(posedge CLK) disable iff (RESET)
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == RAK_REG_CURVE_UNITS
      && ptr.loc != RAK_USER_LOC |-> AVS_READDATA == 32'h0000_0000;
  endproperty
  a_std_refused: assert property (p_std_refused)
    else $error("standard curve location read not zero");

  property p_date;
    @(posedge CLK) disable iff (RESET)
    kp_state == KP_DATE |=> DISPLAY_MSG == RAK_MSG_DATE;
  endproperty
  a_date: assert property (p_date)
    else $error("code date not shown while select held");

endmodule : rak_relay_aout_keypad

`default_nettype wire
